// ===== rtl/low_power_mode_controller.sv
// low-power mode sequencer: sleep, stop and standby entry, regulator choice, wakeup routing
// assumes one 25 MHz core_clk, synchronous active-high reset and synchronous inputs
`timescale 1ns/1ps
module low_power_mode_controller #(
  parameter int unsigned reset_cycles = lpm_pkg::reset_pulse_cycles,
  parameter int unsigned settle_cycles = lpm_pkg::oscillator_settle_cycles
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sleep_request,
  input wire lpm_pkg::lp_mode_e mode_select,
  input wire logic stop_use_low_power_regulator,
  input wire logic stop_under_drive,
  input wire logic regulator_bypassed,
  input wire logic backup_sram_retain,
  input wire logic peripheral_wake,
  input wire logic [lpm_pkg::ext_line_count-1:0] external_event_lines,
  input wire logic supply_voltage_detector,
  input wire logic rtc_event,
  input wire logic usb_wakeup,
  input wire logic ethernet_wakeup,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog_reset,
  input wire logic standby_wakeup_pin,
  output logic cpu_clock_enable,
  output logic peripheral_clock_enable,
  output logic core_clock_enable,
  output logic pll_enable,
  output logic internal_rc_oscillator_enable,
  output logic external_crystal_oscillator_enable,
  output logic main_regulator_enable,
  output logic low_power_regulator_enable,
  output logic regulator_under_drive,
  output logic core_domain_power,
  output logic backup_sram_power,
  output logic core_reset,
  output logic standby_refused,
  output lpm_pkg::lp_mode_e active_mode
);
  import lpm_pkg::*;

  localparam int unsigned count_width = $clog2(reset_cycles + settle_cycles + 1);

  typedef struct packed {
    lpm_state_e state;
    lp_mode_e mode;
    logic [count_width-1:0] count;
    logic cpu_clk_en;
    logic per_clk_en;
    logic core_clk_en;
    logic osc_en;
    logic main_reg_en;
    logic low_power_reg_en;
    logic under_drive;
    logic core_power;
    logic bsram_power;
    logic core_rst;
    logic refused;
  } ctrl_s;

  ctrl_s ctrl_ff;
  ctrl_s nxt_ctrl;
  logic wake_pin_rise;
  logic stop_wake;
  logic standby_exit;

  rise_detect #(
    .width(1)
  ) u_wake_pin_edge (
    .core_clk(core_clk),
    .reset(reset),
    .level_in(standby_wakeup_pin),
    .rise_pulse(wake_pin_rise)
  );

  function automatic logic [count_width-1:0] count_of(input int unsigned n);
    count_of = count_width'(n);
  endfunction

  assign stop_wake = (|external_event_lines) | supply_voltage_detector | rtc_event | usb_wakeup
    | ethernet_wakeup;
  assign standby_exit = ~external_reset_pin_n | independent_watchdog_reset | wake_pin_rise | rtc_event;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl.refused = 1'b0;
    case (ctrl_ff.state)
      st_run: begin
        nxt_ctrl.mode = mode_none;
        if (sleep_request) begin
          // mode is sampled only here; later changes of mode_select are ignored
          case (mode_select)
            mode_sleep: begin
              nxt_ctrl.state = st_sleep;
              nxt_ctrl.mode = mode_sleep;
              nxt_ctrl.cpu_clk_en = 1'b0;
            end
            mode_stop: begin
              nxt_ctrl.state = st_stop;
              nxt_ctrl.mode = mode_stop;
              nxt_ctrl.cpu_clk_en = 1'b0;
              nxt_ctrl.per_clk_en = 1'b0;
              nxt_ctrl.core_clk_en = 1'b0;
              nxt_ctrl.osc_en = 1'b0;
              nxt_ctrl.main_reg_en = ~stop_use_low_power_regulator;
              nxt_ctrl.low_power_reg_en = stop_use_low_power_regulator;
              nxt_ctrl.under_drive = stop_under_drive;
            end
            mode_standby: begin
              if (regulator_bypassed) begin
                // an externally fed core cannot be powered down, so the core keeps running
                nxt_ctrl.refused = 1'b1;
              end else begin
                nxt_ctrl.state = st_standby;
                nxt_ctrl.mode = mode_standby;
                nxt_ctrl.cpu_clk_en = 1'b0;
                nxt_ctrl.per_clk_en = 1'b0;
                nxt_ctrl.core_clk_en = 1'b0;
                nxt_ctrl.osc_en = 1'b0;
                nxt_ctrl.main_reg_en = 1'b0;
                nxt_ctrl.low_power_reg_en = 1'b0;
                nxt_ctrl.core_power = 1'b0;
                nxt_ctrl.core_rst = 1'b1;
                nxt_ctrl.bsram_power = backup_sram_retain;
              end
            end
            default: begin
              nxt_ctrl.state = st_run;
            end
          endcase
        end
      end
      st_sleep: begin
        if (peripheral_wake | stop_wake) begin
          nxt_ctrl.state = st_run;
          nxt_ctrl.mode = mode_none;
          nxt_ctrl.cpu_clk_en = 1'b1;
        end
      end
      st_stop: begin
        if (stop_wake) begin
          nxt_ctrl.state = st_stop_exit;
          nxt_ctrl.osc_en = 1'b1;
          nxt_ctrl.main_reg_en = 1'b1;
          nxt_ctrl.low_power_reg_en = 1'b0;
          nxt_ctrl.under_drive = 1'b0;
          nxt_ctrl.count = count_of(settle_cycles);
        end
      end
      st_stop_exit: begin
        // clocks return only after the oscillator has had time to settle
        if (ctrl_ff.count <= count_of(1)) begin
          nxt_ctrl.state = st_run;
          nxt_ctrl.mode = mode_none;
          nxt_ctrl.cpu_clk_en = 1'b1;
          nxt_ctrl.per_clk_en = 1'b1;
          nxt_ctrl.core_clk_en = 1'b1;
          nxt_ctrl.count = '0;
        end else begin
          nxt_ctrl.count = ctrl_ff.count - count_of(1);
        end
      end
      st_standby: begin
        if (standby_exit) begin
          nxt_ctrl.state = st_reset_seq;
          nxt_ctrl.osc_en = 1'b1;
          nxt_ctrl.main_reg_en = 1'b1;
          nxt_ctrl.core_power = 1'b1;
          nxt_ctrl.bsram_power = 1'b1;
          nxt_ctrl.count = count_of(reset_cycles);
        end
      end
      st_reset_seq: begin
        // core reset held for the full pulse after power returns
        if (ctrl_ff.count <= count_of(1)) begin
          nxt_ctrl.state = st_run;
          nxt_ctrl.mode = mode_none;
          nxt_ctrl.core_rst = 1'b0;
          nxt_ctrl.cpu_clk_en = 1'b1;
          nxt_ctrl.per_clk_en = 1'b1;
          nxt_ctrl.core_clk_en = 1'b1;
          nxt_ctrl.count = '0;
        end else begin
          nxt_ctrl.count = ctrl_ff.count - count_of(1);
        end
      end
      default: begin
        nxt_ctrl.state = st_run;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff.state <= st_run;
      ctrl_ff.mode <= mode_none;
      ctrl_ff.count <= '0;
      ctrl_ff.cpu_clk_en <= 1'b1;
      ctrl_ff.per_clk_en <= 1'b1;
      ctrl_ff.core_clk_en <= 1'b1;
      ctrl_ff.osc_en <= 1'b1;
      ctrl_ff.main_reg_en <= 1'b1;
      ctrl_ff.low_power_reg_en <= 1'b0;
      ctrl_ff.under_drive <= 1'b0;
      ctrl_ff.core_power <= 1'b1;
      ctrl_ff.bsram_power <= 1'b1;
      ctrl_ff.core_rst <= 1'b0;
      ctrl_ff.refused <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign cpu_clock_enable = ctrl_ff.cpu_clk_en;
  assign peripheral_clock_enable = ctrl_ff.per_clk_en;
  assign core_clock_enable = ctrl_ff.core_clk_en;
  assign pll_enable = ctrl_ff.osc_en;
  assign internal_rc_oscillator_enable = ctrl_ff.osc_en;
  assign external_crystal_oscillator_enable = ctrl_ff.osc_en;
  assign main_regulator_enable = ctrl_ff.main_reg_en;
  assign low_power_regulator_enable = ctrl_ff.low_power_reg_en;
  assign regulator_under_drive = ctrl_ff.under_drive;
  assign core_domain_power = ctrl_ff.core_power;
  assign backup_sram_power = ctrl_ff.bsram_power;
  assign core_reset = ctrl_ff.core_rst;
  assign standby_refused = ctrl_ff.refused;
  assign active_mode = ctrl_ff.mode;
endmodule // low_power_mode_controller

// ===== rtl/lpm_pkg.sv
// constants, mode codes and state encoding for the low-power mode controller
// assumes one core_clk domain, synchronous active-high reset, all inputs synchronous
// Summary of operation
// - three low-power modes: sleep, stop, standby
// - sleep halts only the processor core
// - any peripheral interrupt or event wakes sleep
// - stop gates all core-domain clocks, keeps memory
// - stop disables pll and both oscillators
// - stop regulator is main or low-power
// - selected regulator normal or under-drive in stop
// - any event line wakes stop
// - standby switches regulator off, pll, oscillators off
// - standby loses core state except backup domain
// - standby exits on reset, watchdog, wakeup edge, rtc
// - standby refused when regulator is bypassed
// - regulator setting sampled when stop is entered
package lpm_pkg;
  localparam int unsigned ext_line_count = 16;
  localparam int unsigned event_line_count = ext_line_count + 4;
  localparam int unsigned clock_period_ns = 40;
  localparam int unsigned reset_pulse_ns = 20000;
  localparam int unsigned reset_pulse_cycles = (reset_pulse_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int unsigned oscillator_settle_cycles = 16;
  typedef enum logic [1:0] {
    mode_sleep = 2'b00,
    mode_stop = 2'b01,
    mode_standby = 2'b10,
    mode_none = 2'b11
  } lp_mode_e;
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_sleep = 3'b001,
    st_stop = 3'b010,
    st_stop_exit = 3'b011,
    st_standby = 3'b100,
    st_reset_seq = 3'b101
  } lpm_state_e;
endpackage

// ===== rtl/rise_detect.sv
// rising-edge detector for a synchronous level
// assumes the input is already synchronous to core_clk
`timescale 1ns/1ps
module rise_detect #(
  parameter int unsigned width = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [width-1:0] level_in,
  output logic [width-1:0] rise_pulse
);
  typedef struct packed {
    logic [width-1:0] prev;
  } edge_s;
  edge_s state_ff;
  edge_s nxt_state;

  always_comb begin
    nxt_state.prev = level_in;
  end

  assign rise_pulse = level_in & ~state_ff.prev;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // ones at reset so a level already high after reset is not taken as an edge
      state_ff <= '1;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule // rise_detect

// ===== testbench/low_power_mode_controller_tb.sv
// self-checking bench for the low-power mode controller
// assumes short reset and settle counts to keep the run brief
`timescale 1ns/1ps
module low_power_mode_controller_tb;
  import lpm_pkg::*;
  localparam int unsigned rc = 4;
  localparam int unsigned sc = 2;
  logic core_clk = 0, reset = 1, stop_use_low_power_regulator = 0, stop_under_drive = 0;
  logic regulator_bypassed = 0, backup_sram_retain = 0;
  logic [3:0] fire = 0;
  lp_mode_e want = mode_none, mode_select, active_mode;
  logic sleep_request, peripheral_wake, supply_voltage_detector, usb_wakeup, ethernet_wakeup, rtc_event;
  logic independent_watchdog_reset, external_reset_pin_n, standby_wakeup_pin, cpu_clock_enable, pll_enable;
  logic peripheral_clock_enable, core_clock_enable, internal_rc_oscillator_enable, main_regulator_enable;
  logic external_crystal_oscillator_enable, low_power_regulator_enable, regulator_under_drive;
  logic core_domain_power, backup_sram_power, core_reset, standby_refused;
  logic [ext_line_count-1:0] external_event_lines;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  wake_source_model partner (.fire, .want, .sleep_request, .mode_select, .peripheral_wake, .external_event_lines,
    .supply_voltage_detector, .usb_wakeup, .ethernet_wakeup, .rtc_event, .independent_watchdog_reset,
    .external_reset_pin_n, .standby_wakeup_pin);
  low_power_mode_controller #(.reset_cycles(rc), .settle_cycles(sc)) uut (.core_clk, .reset, .sleep_request,
    .mode_select, .stop_use_low_power_regulator, .stop_under_drive, .regulator_bypassed, .backup_sram_retain,
    .peripheral_wake, .external_event_lines, .supply_voltage_detector, .rtc_event, .usb_wakeup, .ethernet_wakeup,
    .external_reset_pin_n, .independent_watchdog_reset, .standby_wakeup_pin, .cpu_clock_enable,
    .peripheral_clock_enable, .core_clock_enable, .pll_enable, .internal_rc_oscillator_enable,
    .external_crystal_oscillator_enable, .main_regulator_enable, .low_power_regulator_enable,
    .regulator_under_drive, .core_domain_power, .backup_sram_power, .core_reset, .standby_refused, .active_mode);
  initial forever #20 core_clk = ~core_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a hang counts as a mismatch and still reaches the report
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input logic [3:0] f);
    fire = f;
    @(negedge core_clk);
  endtask
  task automatic ask(input lp_mode_e m);
    want = m;
    step(4'hf);
  endtask
  task automatic sc_sleep;
    ask(mode_none);
    chk({cpu_clock_enable, active_mode}, {1'b1, mode_none});
    ask(mode_sleep);
    chk({cpu_clock_enable, peripheral_clock_enable, pll_enable, active_mode}, {3'b011, mode_sleep});
    step(4'h1);
    chk({cpu_clock_enable, active_mode}, {1'b1, mode_none});
  endtask
  task automatic sc_stop;
    for (int i = 2; i < 7; i++) begin
      {stop_under_drive, stop_use_low_power_regulator} = i[1:0];
      ask(mode_stop);
      chk({core_domain_power, core_clock_enable, pll_enable, active_mode}, {3'h4, mode_stop});
      chk({internal_rc_oscillator_enable, external_crystal_oscillator_enable}, 8'h0);
      chk({main_regulator_enable, low_power_regulator_enable}, {~i[0], i[0]});
      chk(regulator_under_drive, i[1]);
      step(i[3:0]);
      chk({pll_enable, main_regulator_enable, low_power_regulator_enable, regulator_under_drive}, 8'hc);
      repeat (sc) step(4'h0);
      chk({core_clock_enable, active_mode}, {1'b1, mode_none});
    end
  endtask
  task automatic sc_standby;
    for (int i = 6; i < 10; i++) begin
      backup_sram_retain = i[0];
      ask(mode_standby);
      chk({core_domain_power, core_reset, backup_sram_power}, {2'h1, i[0]});
      chk({pll_enable, main_regulator_enable, active_mode}, {2'h0, mode_standby});
      step(i[3:0]);
      chk({core_domain_power, core_reset, backup_sram_power}, 8'h7);
      repeat (rc) step(4'h0);
      chk({core_reset, cpu_clock_enable, active_mode}, {2'b01, mode_none});
    end
  endtask
  task automatic sc_refuse;
    regulator_bypassed = 1;
    ask(mode_standby);
    chk({standby_refused, core_domain_power, core_reset, active_mode}, {3'b110, mode_none});
    step(4'h0);
    chk(standby_refused, 8'h0);
    regulator_bypassed = 0;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    reset = 0;
    @(negedge core_clk);
    chk({cpu_clock_enable, low_power_regulator_enable, active_mode}, {2'h2, mode_none});
    chk({core_domain_power, core_reset}, 8'h2);
    sc_sleep;
    sc_stop;
    sc_standby;
    sc_refuse;
    print_verdict;
  end
endmodule // low_power_mode_controller_tb
bind low_power_mode_controller lpm_properties checker_i (.core_clk, .reset, .sleep_request, .mode_select,
  .stop_use_low_power_regulator, .stop_under_drive, .regulator_bypassed, .backup_sram_retain, .peripheral_wake,
  .cpu_clock_enable, .peripheral_clock_enable, .core_clock_enable, .pll_enable, .low_power_regulator_enable,
  .regulator_under_drive, .core_domain_power, .backup_sram_power, .core_reset, .standby_refused, .active_mode);

// ===== testbench/lpm_properties.sv
// assertions on the low-power mode controller ports
// assumes a bind onto low_power_mode_controller
`timescale 1ns/1ps
module lpm_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sleep_request,
  input wire lpm_pkg::lp_mode_e mode_select,
  input wire logic stop_use_low_power_regulator,
  input wire logic stop_under_drive,
  input wire logic regulator_bypassed,
  input wire logic backup_sram_retain,
  input wire logic peripheral_wake,
  input wire logic cpu_clock_enable,
  input wire logic peripheral_clock_enable,
  input wire logic core_clock_enable,
  input wire logic pll_enable,
  input wire logic low_power_regulator_enable,
  input wire logic regulator_under_drive,
  input wire logic core_domain_power,
  input wire logic backup_sram_power,
  input wire logic core_reset,
  input wire logic standby_refused,
  input wire lpm_pkg::lp_mode_e active_mode
);
  import lpm_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sleep_gate_a: assert property (
    active_mode == mode_sleep |-> !cpu_clock_enable && peripheral_clock_enable && pll_enable)
    else $error("sleep gating");
  sleep_wake_a: assert property (
    active_mode == mode_sleep && peripheral_wake |=> cpu_clock_enable && active_mode == mode_none)
    else $error("no wake");
  stop_gate_a: assert property (
    $changed(active_mode) && active_mode == mode_stop |-> !core_clock_enable && !pll_enable)
    else $error("stop gating");
  stop_reg_a: assert property (
    $changed(active_mode) && active_mode == mode_stop
      |-> low_power_regulator_enable == $past(stop_use_low_power_regulator)
      && regulator_under_drive == $past(stop_under_drive)) else $error("stop regulator");
  standby_power_a: assert property (
    $changed(active_mode) && active_mode == mode_standby |-> !core_domain_power && !pll_enable && core_reset
      && backup_sram_power == $past(backup_sram_retain)) else $error("standby power");
  standby_refuse_a: assert property (
    regulator_bypassed && sleep_request && mode_select == mode_standby && active_mode == mode_none
      |=> standby_refused && core_domain_power && active_mode == mode_none) else $error("standby not refused");
  mode_ignore_a: assert property (
    sleep_request && mode_select == mode_none && active_mode == mode_none |=> active_mode == mode_none)
    else $error("mode none taken");
  exit_reset_a: assert property (
    $rose(core_domain_power) |-> core_reset ##[1:8] !core_reset) else $error("exit reset");
endmodule // lpm_properties

// ===== testbench/wake_source_model.sv
// core and event sources as one code-driven model
// assumes the bench changes the code on the falling edge
`timescale 1ns/1ps
module wake_source_model (
  input wire logic [3:0] fire,
  input wire lpm_pkg::lp_mode_e want,
  output logic sleep_request,
  output lpm_pkg::lp_mode_e mode_select,
  output logic peripheral_wake,
  output logic [lpm_pkg::ext_line_count-1:0] external_event_lines,
  output logic supply_voltage_detector,
  output logic usb_wakeup,
  output logic ethernet_wakeup,
  output logic rtc_event,
  output logic independent_watchdog_reset,
  output logic external_reset_pin_n,
  output logic standby_wakeup_pin
);
  import lpm_pkg::*;
  // mode is shown with the request so a stale choice is never sampled
  assign mode_select = want;
  assign sleep_request = fire == 4'hf;
  assign peripheral_wake = fire == 4'h1;
  assign external_event_lines = {fire == 4'h2, 14'h0, fire == 4'h2};
  assign supply_voltage_detector = fire == 4'h3;
  assign usb_wakeup = fire == 4'h4;
  assign ethernet_wakeup = fire == 4'h5;
  assign rtc_event = fire == 4'h6;
  assign independent_watchdog_reset = fire == 4'h7;
  assign external_reset_pin_n = fire != 4'h8;
  assign standby_wakeup_pin = fire == 4'h9;
endmodule // wake_source_model
